// File: bench/dsc_decode_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// decode output checks
// ----------------------------------------
module dsc_decode_checker (
  input wire logic                          clk,
  input wire logic                          nrst,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pready,
  input wire logic [23:0]                   fetch_word,
  input wire logic                          cond_true,
  input wire logic                          issue_valid,
  input wire dsc_decode_pkg::decode_class_t issue_class,
  input wire logic [7:0]                    issue_opcode,
  input wire logic [1:0]                    issue_cycles,
  input wire logic                          issue_double,
  input wire logic [12:0]                   file_addr,
  input wire logic                          file_to_default,
  input wire logic [3:0]                    bit_pos,
  input wire logic                          bit_indirect,
  input wire logic                          awb_write,
  input wire logic                          awb_postinc,
  input wire logic [22:0]                   prog_addr
);
  import dsc_decode_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not a single access cycle");
  a_opcode_taken: assert property (issue_valid && !issue_double && issue_class != cls_skip
    |-> issue_opcode == $past(fetch_word[23:16])) else $error("issued opcode differs from word");
  a_double_ops: assert property (issue_valid && issue_double |-> issue_opcode inside {8'h02, 8'h04, 8'h08})
    else $error("double issue for wrong opcode");
  a_double_join: assert property (issue_valid && issue_double |-> issue_cycles == 2'h2
    && prog_addr[22:16] == $past(fetch_word[6:0])) else $error("double word join wrong");
  a_cond_cycles: assert property (issue_valid && issue_class == cls_cond
    |-> issue_cycles == {1'b0, $past(cond_true)} + 2'h1) else $error("conditional cycle count wrong");
  a_skip_cycles: assert property (issue_valid && issue_class == cls_skip && issue_cycles != 2'h1
    |-> (issue_cycles == 2'h3) == ($past(fetch_word[23:16]) inside {8'h02, 8'h04, 8'h08}))
    else $error("skip cycle count wrong");
  a_ctrl_cycles: assert property (issue_valid && issue_class inside {cls_branch, cls_table, cls_return}
    |-> issue_cycles == (issue_class == cls_return ? 2'h3 : 2'h2)) else $error("control cycle count wrong");
  a_file_fields: assert property (issue_valid && issue_class == cls_file
    |-> file_addr == $past(fetch_word[12:0]) && file_to_default == !$past(fetch_word[13]))
    else $error("file operand fields wrong");
  a_bit_fields: assert property (issue_valid && issue_class == cls_bit
    |-> bit_pos == $past(fetch_word[15:12]) && bit_indirect == $past(fetch_word[11]))
    else $error("bit operand fields wrong");
  a_awb_dest: assert property (issue_valid && issue_class == cls_mac
    |-> awb_write == ($past(fetch_word[1:0]) inside {2'h1, 2'h2}) && awb_postinc == ($past(fetch_word[1:0]) == 2'h2))
    else $error("write-back destination wrong");
endmodule

bind dsc_instruction_format_decode dsc_decode_checker u_chk (
  .clk, .nrst, .psel, .penable, .pready, .fetch_word, .cond_true, .issue_valid, .issue_class, .issue_opcode,
  .issue_cycles, .issue_double, .file_addr, .file_to_default, .bit_pos, .bit_indirect, .awb_write, .awb_postinc,
  .prog_addr
);
`default_nettype wire

// File: bench/prog_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// program memory feeding the decoder
// ----------------------------------------
module prog_mem_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        fetch_ready,
  output var  logic        fetch_valid,
  output var  logic [23:0] fetch_word,
  output var  logic        cond_true
);
  logic [24:0] q[$];
  int          n;

  initial begin
    fetch_valid = 1'b0;
    fetch_word = 24'h000000;
    cond_true = 1'b0;
  end

  // a word is held until taken; one stall in four splits two-word pairs too
  // idle cycles show the inverse so a stale word never passes for a fresh one
  always @(posedge clk) begin
    if (!nrst) begin
      fetch_valid <= 1'b0;
      n <= 0;
    end else if (!fetch_valid || fetch_ready) begin
      n <= n + 1;
      if (q.size() > 0 && n % 4 != 3) begin
        {cond_true, fetch_word} <= q.pop_front();
        fetch_valid <= 1'b1;
      end else begin
        {cond_true, fetch_word} <= ~{cond_true, fetch_word};
        fetch_valid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import dsc_decode_pkg::*;
  typedef struct {decode_class_t c; logic [7:0] op; logic [1:0] cy; logic dbl; logic [23:0] w; logic [22:0] pa;} exp_t;
  logic          clk, nrst, psel, penable, pwrite, pready, pslverr, fetch_valid, fetch_ready, cond_true, flag_update;
  logic          issue_valid, issue_double, file_to_default, byte_mode, bit_indirect, acc_b, awb_write, awb_postinc;
  logic          shift_from_reg;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, r;
  logic [23:0]   fetch_word, fw;
  logic [8:0]    flag_value, fv;
  decode_class_t issue_class;
  logic [7:0]    issue_opcode;
  logic [1:0]    issue_cycles, x_dest, y_dest;
  logic [3:0]    base_work_reg, source_work_reg, dest_work_reg, bit_pos, x_prefetch, y_prefetch, shift_count_reg;
  logic [3:0]    dsp_flags;
  logic [2:0]    source_mode, dest_mode, mult_pair;
  logic [12:0]   file_addr;
  logic [9:0]    literal;
  logic [5:0]    shift_literal;
  logic [22:0]   prog_addr;
  logic [4:0]    mcu_flags;
  logic [32:0]   rr;
  exp_t          eq[$];
  exp_t          m;
  int            seed = 79672;
  int            err_count, check_count, n_exp, st, cyc_n;
  logic [8:0]    prog[26] = '{9'h040, 9'h043, 9'h0b4, 9'h0a8, 9'h0b0, 9'h0c0, 9'h0c3, 9'h0c8, 9'h000, 9'h001,
    9'h006, 9'h007, 9'h031, 9'h131, 9'h037, 9'h0ba, 9'h0bb, 9'h0a6, 9'h1a6, 9'h040, 9'h1a6, 9'h004, 9'h002,
    9'h008, 9'h1a6, 9'h0b4};

  dsc_instruction_format_decode u_dut (.paddr, .clk, .nrst, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .fetch_valid, .fetch_word, .fetch_ready, .cond_true, .flag_update, .flag_value, .issue_valid,
    .issue_class, .issue_opcode, .issue_cycles, .issue_double, .base_work_reg, .source_work_reg, .source_mode,
    .dest_work_reg, .dest_mode, .file_addr, .file_to_default, .byte_mode, .bit_pos, .bit_indirect, .literal,
    .acc_b, .mult_pair, .x_prefetch, .x_dest, .y_prefetch, .y_dest, .awb_write, .awb_postinc, .shift_from_reg,
    .shift_count_reg, .shift_literal, .prog_addr, .mcu_flags, .dsp_flags);
  prog_mem_model u_mem (.clk, .nrst, .fetch_ready, .fetch_valid, .fetch_word, .cond_true);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------
  // checking and reference model
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  function automatic decode_class_t cls_of(input logic [7:0] op);
    case (op)
      8'h00: return cls_nop;
      8'h01: return cls_indirect;
      8'h06, 8'h07: return cls_return;
      8'h31: return cls_cond;
      8'h37: return cls_branch;
      8'ha6: return cls_skip;
      8'ha8: return cls_bit;
      8'hb0: return cls_lit;
      8'hb4: return cls_file;
      8'hba, 8'hbb: return cls_table;
      8'hc8: return cls_dsp;
      default: return op[7:2] == 6'h10 ? cls_word : op[7:2] == 6'h30 ? cls_mac : cls_illegal;
    endcase
  endfunction

  // zero stands for "two or three": the indirect cycle count is left open
  function automatic logic [1:0] cyc(input logic [7:0] op, input logic c);
    case (op)
      8'h06, 8'h07: return 2'h3;
      8'h37, 8'hba, 8'hbb: return 2'h2;
      8'h31: return c ? 2'h2 : 2'h1;
      8'h01: return 2'h0;
      default: return 2'h1;
    endcase
  endfunction

  task automatic put(input exp_t e);
    eq.push_back(e);
    n_exp++;
  endtask

  task automatic feed(input logic c, input logic [23:0] w);
    logic [7:0] op;
    op = w[23:16];
    u_mem.q.push_back({c, w});
    case (st)
      1: begin
        put(exp_t'{cls_double, fw[23:16], 2'h2, 1'b1, w, {w[6:0], fw[15:0]}});
        st = 0;
      end
      2: begin
        put(exp_t'{cls_skip, 8'ha6, op inside {8'h02, 8'h04, 8'h08} ? 2'h3 : 2'h2, 1'b0, w, {7'h00, fw[15:0]}});
        st = op inside {8'h02, 8'h04, 8'h08} ? 3 : 0;
      end
      3: st = 0;
      default: begin
        fw = w;
        if (op inside {8'h02, 8'h04, 8'h08}) st = 1;
        else if (op == 8'ha6 && c) st = 2;
        else put(exp_t'{cls_of(op), op, cyc(op, c), 1'b0, w, {7'h00, w[15:0]}});
      end
    endcase
  endtask

  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_count++;
      summarize();
    end
    if (issue_valid === 1'b1) begin
      m = eq.pop_front();
      chk(issue_class, m.c);
      chk(issue_opcode, m.op);
      if (m.cy == 2'h0) chk(issue_cycles[1], 1'b1);
      else chk(issue_cycles, m.cy);
      chk(issue_double, m.dbl);
      chk(awb_write, m.c == cls_mac && m.w[1:0] inside {2'h1, 2'h2});
      chk(prog_addr, m.pa);
      if (m.c == cls_word) chk({base_work_reg, dest_mode, dest_work_reg, source_mode, source_work_reg}, m.w[17:0]);
      if (m.c == cls_mac) chk({acc_b, mult_pair, x_prefetch, x_dest, y_prefetch, y_dest}, {m.w[15:2], m.w[17:16]});
      if (m.c == cls_dsp) chk({acc_b, shift_from_reg, shift_literal}, {m.w[15], ~m.w[14], m.w[13:8]});
      if (m.c == cls_lit) chk({byte_mode, literal}, m.w[14:4]);
    end
  end

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rc(input logic [11:0] a, input logic [32:0] e);
    logic [32:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic drain();
    repeat (400) if (eq.size() > 0) @(posedge clk);
    repeat (4) @(posedge clk);
    chk(eq.size(), 0);
  endtask

  initial begin
    {nrst, psel, penable, pwrite, flag_update} = '0;
    {paddr, pwdata, flag_value} = '0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rc(12'h000, 33'h1);
    rc(12'h004, 33'h0);
    rc(12'h008, 33'h0);
    rc(12'h010, 33'h0);
    rc(12'h020, 33'h1_0000_0000);
    for (int k = 0; k < 2; k++) begin
      foreach (prog[i]) begin
        r = $random(seed);
        feed(prog[i][8], {prog[i][7:0], r[15:1], 1'b0});
        if (prog[i][7:0] inside {8'h02, 8'h04, 8'h08}) feed(1'b0, {8'h00, r[31:16]});
      end
    end
    feed(1'b0, 24'h021234);
    feed(1'b0, 24'h5a0001);
    feed(1'b0, 24'h040001);
    feed(1'b0, 24'h000003);
    feed(1'b0, 24'hb07ff0);
    feed(1'b0, 24'hc00003);
    feed(1'b0, 24'hff0000);
    drain();
    rc(12'h004, 33'h1f);
    apb(1'b1, 12'h004, 32'h1f, rr);
    rc(12'h004, 33'h0);
    apb(1'b1, 12'h020, 32'h5, rr);
    chk(rr[32], 1'b1);
    apb(1'b1, 12'h000, 32'h0, rr);
    repeat (2) @(posedge clk);
    chk(fetch_ready, 1'b0);
    feed(1'b0, 24'h400000);
    repeat (6) @(posedge clk);
    chk(eq.size(), 1);
    apb(1'b1, 12'h000, 32'h1, rr);
    drain();
    rc(12'h010, {1'b0, n_exp[31:0]});
    rc(12'h00c, 33'h4011);
    for (int i = 0; i < 3; i++) begin
      fv = $random(seed);
      flag_update <= 1'b1;
      flag_value <= fv;
      @(posedge clk);
      flag_update <= 1'b0;
      repeat (3) @(posedge clk);
      chk({dsp_flags, mcu_flags}, fv);
      rc(12'h008, {21'h0, fv[8:5], 3'h0, fv[4:0]});
    end
    apb(1'b1, 12'h008, 32'h0a15, rr);
    repeat (3) @(posedge clk);
    chk({dsp_flags, mcu_flags}, 9'h155);
    summarize();
  end
endmodule
`default_nettype wire

// File: rtl/dsc_decode_defines.svh
`ifndef DSC_DECODE_DEFINES_SVH
`define DSC_DECODE_DEFINES_SVH

// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define REG_CTRL      12'h000
`define REG_STATUS    12'h004
`define REG_FLAGS     12'h008
`define REG_LAST      12'h00c
`define REG_COUNT     12'h010

`define CTRL_RESET    1'h1
`define FLAGS_RESET   9'h000
`define COUNT_RESET   32'h0000_0000

// status error bits, write one to clear
`define ERR_SECOND    0
`define ERR_LIT       1
`define ERR_ADDR      2
`define ERR_AWB       3
`define ERR_ILLEGAL   4
`define ERR_W         5

// ----------------------------------------
// opcodes and opcode groups
// ----------------------------------------
`define OP_NOP        8'h00
`define OP_INDIRECT   8'h01
`define OP_CALL_DW    8'h02
`define OP_JUMP_DW    8'h04
`define OP_RETURN     8'h06
`define OP_RETINT     8'h07
`define OP_MOVE_DW    8'h08
`define OP_COND_BR    8'h31
`define OP_UNCOND_BR  8'h37
`define OP_SKIP       8'ha6
`define OP_BIT        8'ha8
`define OP_LIT        8'hb0
`define OP_FILE       8'hb4
`define OP_TABLE_RD   8'hba
`define OP_TABLE_WR   8'hbb
`define OP_DSP        8'hc8
`define GRP_WORD      6'h10
`define GRP_MAC       6'h30

// ----------------------------------------
// instruction word fields
// ----------------------------------------
`define F_OPCODE      23:16
`define F_WBASE       17:14
`define F_DEST_MODE   13:11
`define F_DEST_REG    10:7
`define F_SRC_MODE    6:4
`define F_SRC_REG     3:0
`define F_FILE_ADDR   12:0
`define B_FILE_DEST   13
`define B_BYTE        14
`define F_LIT10       13:4
`define F_BIT_POS     15:12
`define B_BIT_IND     11
`define F_BIT_BASE    10:7
`define B_ACC         15
`define F_MULT        14:12
`define F_XPRE        11:8
`define F_XDEST       7:6
`define F_YPRE        5:2
`define F_AWB         1:0
`define F_YDEST       17:16
`define B_SHIFT_LIT   14
`define F_SHIFT_LIT   13:8
`define F_SHIFT_REG   11:8
`define F_ADDR_LO     15:0
`define F_ADDR_HI     6:0

`define MAX_BYTE_LIT  10'h0ff
`define AWB_NONE      2'h0
`define AWB_DIRECT    2'h1
`define AWB_POSTINC   2'h2
`define CYC_ONE       2'h1
`define CYC_TWO       2'h2
`define CYC_THREE     2'h3

`endif

// File: rtl/dsc_decode_pkg.sv
package dsc_decode_pkg;

  typedef enum logic [3:0] {
    cls_nop, cls_word, cls_file, cls_bit, cls_lit, cls_mac, cls_dsp, cls_cond,
    cls_branch, cls_indirect, cls_table, cls_return, cls_skip, cls_double, cls_illegal
  } decode_class_t;

  typedef enum logic [1:0] {
    st_first, st_second, st_skip, st_drop
  } fsm_state_t;

endpackage

// File: rtl/dsc_instruction_format_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "dsc_decode_defines.svh"

module dsc_instruction_format_decode (
  input  wire logic [11:0]                   paddr,
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output var  logic [31:0]                   prdata,
  output var  logic                          pready,
  output var  logic                          pslverr,
  input  wire logic                          fetch_valid,
  input  wire logic [23:0]                   fetch_word,
  output var  logic                          fetch_ready,
  input  wire logic                          cond_true,
  input  wire logic                          flag_update,
  input  wire logic [8:0]                    flag_value,
  output var  logic                          issue_valid,
  output var  dsc_decode_pkg::decode_class_t issue_class,
  output var  logic [7:0]                    issue_opcode,
  output var  logic [1:0]                    issue_cycles,
  output var  logic                          issue_double,
  output var  logic [3:0]                    base_work_reg,
  output var  logic [3:0]                    source_work_reg,
  output var  logic [2:0]                    source_mode,
  output var  logic [3:0]                    dest_work_reg,
  output var  logic [2:0]                    dest_mode,
  output var  logic [12:0]                   file_addr,
  output var  logic                          file_to_default,
  output var  logic                          byte_mode,
  output var  logic [3:0]                    bit_pos,
  output var  logic                          bit_indirect,
  output var  logic [9:0]                    literal,
  output var  logic                          acc_b,
  output var  logic [2:0]                    mult_pair,
  output var  logic [3:0]                    x_prefetch,
  output var  logic [1:0]                    x_dest,
  output var  logic [3:0]                    y_prefetch,
  output var  logic [1:0]                    y_dest,
  output var  logic                          awb_write,
  output var  logic                          awb_postinc,
  output var  logic                          shift_from_reg,
  output var  logic [3:0]                    shift_count_reg,
  output var  logic [5:0]                    shift_literal,
  output var  logic [22:0]                   prog_addr,
  output var  logic [4:0]                    mcu_flags,
  output var  logic [3:0]                    dsp_flags
);
  import dsc_decode_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  fsm_state_t       state;
  fsm_state_t       next_state;
  decode_class_t    fetch_class;
  decode_class_t    held_class;
  decode_class_t    next_class;
  logic             fetch_double;
  logic [23:0]      held_word;
  logic [23:0]      w1;
  logic [23:0]      w2;
  logic             do_issue;
  logic             next_double;
  logic [1:0]       next_cycles;
  logic             accept;
  logic             enable;
  logic [`ERR_W-1:0] err;
  logic [`ERR_W-1:0] next_err;
  logic [31:0]      issued;
  logic             apb_setup;
  logic             apb_write;

  function automatic logic [1:0] single_cycles(input decode_class_t c, input logic cond);
    logic [1:0] n;
    n = `CYC_ONE;
    case (c)
      cls_cond:     n = cond ? `CYC_TWO : `CYC_ONE;
      cls_branch,
      cls_indirect,
      cls_table:    n = `CYC_TWO;
      cls_return:   n = `CYC_THREE;
      default:      n = `CYC_ONE;
    endcase
    return n;
  endfunction

  op_classifier classify (
    .opcode    (fetch_word[`F_OPCODE]),
    .op_class  (fetch_class),
    .is_double (fetch_double)
  );

  assign accept    = fetch_valid & fetch_ready;
  assign apb_setup = psel & ~penable;
  // writes land at the access edge, together with the answer
  assign apb_write = psel & penable & pready & pwrite;

  // ----------------------------------------
  // word sequencing
  // ----------------------------------------
  always_comb begin
    do_issue    = 1'b0;
    w1          = fetch_word;
    w2          = 24'h00_0000;
    next_class  = fetch_class;
    next_cycles = `CYC_ONE;
    next_double = 1'b0;
    next_state  = state;
    if (accept) begin
      unique case (state)
        st_first: begin
          if (fetch_double) begin
            next_state = st_second;
          end else if (fetch_class == cls_skip && cond_true) begin
            next_state = st_skip;
          end else begin
            do_issue    = 1'b1;
            next_cycles = single_cycles(fetch_class, cond_true);
          end
        end
        st_second: begin
          do_issue    = 1'b1;
          w1          = held_word;
          w2          = fetch_word;
          next_class  = held_class;
          next_cycles = `CYC_TWO;
          next_double = 1'b1;
          next_state  = st_first;
        end
        st_skip: begin
          do_issue    = 1'b1;
          w1          = held_word;
          next_class  = held_class;
          next_cycles = fetch_double ? `CYC_THREE : `CYC_TWO;
          next_state  = fetch_double ? st_drop : st_first;
        end
        st_drop: begin
          next_state = st_first;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state      <= st_first;
      held_word  <= 24'h00_0000;
      held_class <= cls_nop;
    end else begin
      state <= next_state;
      if (accept && state == st_first) begin
        held_word  <= fetch_word;
        held_class <= fetch_class;
      end
    end
  end

  // ----------------------------------------
  // error detection
  // ----------------------------------------
  always_comb begin
    next_err = '0;
    // a skipped second word is discarded unchecked
    next_err[`ERR_SECOND]  = accept && state == st_second && fetch_word[`F_OPCODE] != 8'h00;
    next_err[`ERR_LIT]     = do_issue && next_class == cls_lit && w1[`B_BYTE]
                             && w1[`F_LIT10] > `MAX_BYTE_LIT;
    next_err[`ERR_ADDR]    = do_issue && next_double && w1[`F_OPCODE] != `OP_MOVE_DW && w1[0];
    next_err[`ERR_AWB]     = do_issue && next_class == cls_mac && w1[`F_AWB] == 2'h3;
    next_err[`ERR_ILLEGAL] = do_issue && next_class == cls_illegal;
  end

  // ----------------------------------------
  // issued operation and operand fields
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      issue_valid  <= 1'b0;
      issue_class  <= cls_nop;
      issue_opcode <= 8'h00;
      issue_cycles <= `CYC_ONE;
      issue_double <= 1'b0;
    end else begin
      issue_valid <= do_issue;
      if (do_issue) begin
        issue_class  <= next_class;
        issue_opcode <= w1[`F_OPCODE];
        issue_cycles <= next_cycles;
        issue_double <= next_double;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      {base_work_reg, source_work_reg, source_mode, dest_work_reg, dest_mode} <= '0;
      {file_addr, file_to_default, byte_mode, bit_pos, bit_indirect, literal} <= '0;
    end else if (do_issue) begin
      // base register for word ops carries no mode field
      base_work_reg   <= (next_class == cls_bit) ? w1[`F_BIT_BASE] : w1[`F_WBASE];
      source_work_reg <= w1[`F_SRC_REG];
      source_mode     <= w1[`F_SRC_MODE];
      dest_work_reg   <= w1[`F_DEST_REG];
      dest_mode       <= w1[`F_DEST_MODE];
      file_addr       <= w1[`F_FILE_ADDR];
      file_to_default <= ~w1[`B_FILE_DEST];
      byte_mode       <= w1[`B_BYTE];
      bit_pos         <= w1[`F_BIT_POS];
      bit_indirect    <= w1[`B_BIT_IND];
      literal         <= w1[`F_LIT10];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      {acc_b, mult_pair, x_prefetch, x_dest, y_prefetch, y_dest} <= '0;
      {awb_write, awb_postinc, shift_from_reg, shift_count_reg, shift_literal, prog_addr} <= '0;
    end else if (do_issue) begin
      acc_b           <= w1[`B_ACC];
      mult_pair       <= w1[`F_MULT];
      x_prefetch      <= w1[`F_XPRE];
      x_dest          <= w1[`F_XDEST];
      y_prefetch      <= w1[`F_YPRE];
      y_dest          <= w1[`F_YDEST];
      // the illegal fourth code writes nothing back
      awb_write       <= next_class == cls_mac && (w1[`F_AWB] == `AWB_DIRECT || w1[`F_AWB] == `AWB_POSTINC);
      awb_postinc     <= next_class == cls_mac && w1[`F_AWB] == `AWB_POSTINC;
      shift_from_reg  <= ~w1[`B_SHIFT_LIT];
      shift_count_reg <= w1[`F_SHIFT_REG];
      shift_literal   <= w1[`F_SHIFT_LIT];
      prog_addr       <= {w2[`F_ADDR_HI], w1[`F_ADDR_LO]};
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  // datapath update wins over a software write in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {dsp_flags, mcu_flags} <= `FLAGS_RESET;
    end else if (flag_update) begin
      {dsp_flags, mcu_flags} <= flag_value;
    end else if (apb_write && paddr == `REG_FLAGS) begin
      {dsp_flags, mcu_flags} <= {pwdata[11:8], pwdata[4:0]};
    end
  end

  // ----------------------------------------
  // control, errors, counter
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      enable      <= `CTRL_RESET;
      fetch_ready <= 1'b0;
    end else begin
      if (apb_write && paddr == `REG_CTRL) begin
        enable <= pwdata[0];
      end
      // ready lags enable by one cycle; a held first word stays held while off
      fetch_ready <= enable;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      err <= '0;
    end else begin
      // a new error wins over its clear
      if (apb_write && paddr == `REG_STATUS) begin
        err <= (err & ~pwdata[`ERR_W-1:0]) | next_err;
      end else begin
        err <= err | next_err;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      issued <= `COUNT_RESET;
    end else if (do_issue) begin
      issued <= issued + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // apb slave, no wait states
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_setup;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (apb_setup) begin
        case (paddr)
          `REG_CTRL:   prdata <= {31'h0000_0000, enable};
          `REG_STATUS: prdata <= {22'h00_0000, 2'(state), 3'h0, err};
          `REG_FLAGS:  prdata <= {20'h0_0000, dsp_flags, 3'h0, mcu_flags};
          `REG_LAST:   prdata <= {16'h0000, issue_opcode, 2'h0, issue_cycles, issue_class};
          `REG_COUNT:  prdata <= issued;
          default:     pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// File: rtl/op_classifier.sv
`timescale 1ns/10ps
`default_nettype none
`include "dsc_decode_defines.svh"

module op_classifier (
  input  wire logic [7:0]                    opcode,
  output var  dsc_decode_pkg::decode_class_t op_class,
  output var  logic                          is_double
);
  import dsc_decode_pkg::*;

  // ----------------------------------------
  // opcode to class
  // ----------------------------------------
  always_comb begin
    is_double = 1'b0;
    op_class  = cls_illegal;
    if (opcode[7:2] == `GRP_WORD) begin
      op_class = cls_word;
    end else if (opcode[7:2] == `GRP_MAC) begin
      op_class = cls_mac;
    end else begin
      case (opcode)
        `OP_NOP:       op_class = cls_nop;
        `OP_INDIRECT:  op_class = cls_indirect;
        `OP_RETURN,
        `OP_RETINT:    op_class = cls_return;
        `OP_COND_BR:   op_class = cls_cond;
        `OP_UNCOND_BR: op_class = cls_branch;
        `OP_SKIP:      op_class = cls_skip;
        `OP_BIT:       op_class = cls_bit;
        `OP_LIT:       op_class = cls_lit;
        `OP_FILE:      op_class = cls_file;
        `OP_TABLE_RD,
        `OP_TABLE_WR:  op_class = cls_table;
        `OP_DSP:       op_class = cls_dsp;
        `OP_CALL_DW,
        `OP_JUMP_DW,
        `OP_MOVE_DW: begin
          op_class  = cls_double;
          is_double = 1'b1;
        end
        default:       op_class = cls_illegal;
      endcase
    end
  end

endmodule

`default_nettype wire
